//--- rtl/hha_pkg.sv
// Purpose: Constants and carrier types for the holdover history accumulator control.
// Assumes: 10 MHz system clock, byte-wide register port.
// Notes: Offsets are byte addresses on the register port.
package hha_pkg;
    localparam logic [15:0] OFS_PERIOD_BYTE0 = 16'h140a;
    localparam logic [15:0] OFS_PERIOD_BYTE1 = 16'h140b;
    localparam logic [15:0] OFS_PERIOD_BYTE2 = 16'h140c;
    localparam logic [15:0] OFS_PERIOD_BYTE3 = 16'h140d;
    localparam logic [15:0] OFS_GATING = 16'h140e;
    localparam logic [15:0] OFS_HOLDOFF = 16'h1410;
    localparam logic [15:0] OFS_STATUS = 16'h1412;

    localparam int GATE_SLEW_BIT = 5;
    localparam int GATE_FREQ_BIT = 4;
    localparam int GATE_PHASE_BIT = 3;
    localparam int QUICK_BIT = 2;
    localparam int SINGLE_BIT = 1;
    localparam int PERSIST_BIT = 0;

    localparam logic [27:0] PERIOD_RESET = 28'h000_000a;
    localparam logic [7:0] GATING_RESET = 8'h38;
    localparam logic [7:0] HOLDOFF_RESET = 8'h00;

    localparam int CLOCK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYCLES = CLOCK_HZ / MS_PER_S;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } hha_bus_s;

    typedef struct packed {
        logic slew_active;
        logic freq_lock;
        logic phase_lock;
        logic holdover;
    } hha_loop_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GATED,
        ST_HOLDOFF,
        ST_AVERAGE
    } hha_phase_e;
endpackage : hha_pkg

//--- rtl/hha_ms_tick.sv
// Purpose: One-cycle pulse every millisecond of system clock.
// Assumes: Count derived from the clock rate in the package.
// Notes: Restarts when i_restart is high.
`timescale 1ns/100ps
`default_nettype none
module hha_ms_tick (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Control
    input wire logic i_restart,
    output logic o_tick
);
    typedef struct packed {
        logic [13:0] count;
        logic tick;
    } hha_tick_s;

    hha_tick_s state;
    hha_tick_s next_state;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (i_restart) begin
            next_state.count = 14'h0000;
        end else if (state.count == 14'(hha_pkg::TICK_CYCLES - 1)) begin
            next_state.count = 14'h0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 14'h0001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_tick = state.tick;
endmodule : hha_ms_tick
`default_nettype wire

//--- rtl/hha_ctrl.sv
// Purpose: Gates, holds off and times the tuning-word history averaging window.
// Assumes: Loop status inputs are synchronous to i_clock.
// Notes: Averages one tuning-word sample per millisecond; holdover value is registered.
`timescale 1ns/100ps
`default_nettype none
module hha_ctrl (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire hha_pkg::hha_bus_s i_bus,
    output logic [7:0] o_rdata,
    // Loop status
    input wire hha_pkg::hha_loop_s i_loop,
    input wire logic [45:0] i_tuning_word,
    // Holdover result
    output logic o_history_valid,
    output logic o_holdover_valid,
    output logic [45:0] o_holdover_word,
    output logic o_averaging
);
    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [27:0] period;
        logic [7:0] gating;
        logic [7:0] holdoff;
        hha_pkg::hha_phase_e phase;
        logic [27:0] ms_count;
        logic [7:0] hold_count;
        logic [73:0] acc;
        logic [27:0] samples;
        logic [45:0] history;
        logic have_history;
        logic was_holdover;
        logic [7:0] rdata;
        logic [45:0] out_word;
        logic out_valid;
        logic averaging;
    } hha_ctrl_s;

    hha_ctrl_s state;
    hha_ctrl_s next_state;
    logic tick;
    logic gate_ok;
    logic restart_tick;
    logic reacquire;
    logic [27:0] quarter;

    // Millisecond time base
    hha_ms_tick hha_ms_tick_i (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_restart(restart_tick),
        .o_tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gating and timing
    always_comb begin
        gate_ok = (!state.gating[hha_pkg::GATE_SLEW_BIT] || !i_loop.slew_active)
            && (!state.gating[hha_pkg::GATE_FREQ_BIT] || i_loop.freq_lock)
            && (!state.gating[hha_pkg::GATE_PHASE_BIT] || i_loop.phase_lock);
        reacquire = state.was_holdover && !i_loop.holdover;
        restart_tick = (state.phase == hha_pkg::ST_IDLE) || (state.phase == hha_pkg::ST_GATED);
        // Quick start threshold
        quarter = {2'b00, state.period[27:2]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file, sequencer and holdover value
    always_comb begin
        next_state = state;
        next_state.was_holdover = i_loop.holdover;
        // Register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                hha_pkg::OFS_PERIOD_BYTE0: next_state.period[7:0] = i_bus.wdata;
                hha_pkg::OFS_PERIOD_BYTE1: next_state.period[15:8] = i_bus.wdata;
                hha_pkg::OFS_PERIOD_BYTE2: next_state.period[23:16] = i_bus.wdata;
                // Reserved bits are dropped on write
                hha_pkg::OFS_PERIOD_BYTE3: next_state.period[27:24] = i_bus.wdata[3:0];
                hha_pkg::OFS_GATING: next_state.gating = {2'b00, i_bus.wdata[5:0]};
                hha_pkg::OFS_HOLDOFF: next_state.holdoff = i_bus.wdata;
                default: begin
                end
            endcase
        end

        // Register reads
        next_state.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr)
                hha_pkg::OFS_PERIOD_BYTE0: next_state.rdata = state.period[7:0];
                hha_pkg::OFS_PERIOD_BYTE1: next_state.rdata = state.period[15:8];
                hha_pkg::OFS_PERIOD_BYTE2: next_state.rdata = state.period[23:16];
                hha_pkg::OFS_PERIOD_BYTE3: next_state.rdata = {4'h0, state.period[27:24]};
                hha_pkg::OFS_GATING: next_state.rdata = state.gating;
                hha_pkg::OFS_HOLDOFF: next_state.rdata = state.holdoff;
                hha_pkg::OFS_STATUS: next_state.rdata = {4'h0, state.have_history,
                    state.out_valid, state.phase};
                // Unmapped addresses read as zero
                default: next_state.rdata = 8'h00;
            endcase
        end

        // Sequencer
        case (state.phase)
            hha_pkg::ST_IDLE: begin
                // Averaging only starts once the loop leaves holdover
                if (!i_loop.holdover) begin
                    next_state.phase = hha_pkg::ST_GATED;
                end
            end
            hha_pkg::ST_GATED: begin
                // Loss of reference before the window opens returns to idle
                if (i_loop.holdover) begin
                    next_state.phase = hha_pkg::ST_IDLE;
                end else if (gate_ok) begin
                    next_state.hold_count = 8'h00;
                    next_state.ms_count = 28'h000_0000;
                    if (state.holdoff == 8'h00) begin
                        next_state.phase = hha_pkg::ST_AVERAGE;
                    end else begin
                        next_state.phase = hha_pkg::ST_HOLDOFF;
                    end
                end
            end
            hha_pkg::ST_HOLDOFF: begin
                // Loss of reference aborts the hold-off
                if (i_loop.holdover) begin
                    next_state.phase = hha_pkg::ST_IDLE;
                end else if (tick) begin
                    next_state.hold_count = state.hold_count + 8'h01;
                    if (state.hold_count + 8'h01 >= state.holdoff) begin
                        next_state.phase = hha_pkg::ST_AVERAGE;
                    end
                end
            end
            hha_pkg::ST_AVERAGE: begin
                // One sample per millisecond keeps the counters in range for any period
                if (tick) begin
                    next_state.acc = state.acc + {28'h000_0000, i_tuning_word};
                    next_state.samples = state.samples + 28'h000_0001;
                    next_state.ms_count = state.ms_count + 28'h000_0001;
                    if (state.gating[hha_pkg::QUICK_BIT] && !state.have_history
                        && state.ms_count + 28'h000_0001 >= quarter) begin
                        next_state.history =
                            46'(next_state.acc / {46'h0, next_state.samples});
                        next_state.have_history = 1'b1;
                    end
                    // Period end: store the average and open a fresh window
                    if (state.ms_count + 28'h000_0001 >= state.period) begin
                        next_state.history = 46'(next_state.acc / {46'h0, next_state.samples});
                        next_state.have_history = 1'b1;
                        next_state.ms_count = 28'h000_0000;
                        next_state.acc = 74'h0;
                        next_state.samples = 28'h000_0000;
                    end
                end
                // Holdover drops the partial window
                if (i_loop.holdover) begin
                    next_state.phase = hha_pkg::ST_IDLE;
                    next_state.acc = 74'h0;
                    next_state.samples = 28'h000_0000;
                end
            end
            default: next_state.phase = hha_pkg::ST_IDLE;
        endcase
        // A first store into an empty history in the same cycle wins over the reacquire clear
        if (reacquire && !state.gating[hha_pkg::PERSIST_BIT]
            && !(next_state.have_history && !state.have_history)) begin
            next_state.have_history = 1'b0;
            next_state.history = 46'h0;
        end

        // Holdover value
        if (next_state.have_history) begin
            next_state.out_word = next_state.history;
            next_state.out_valid = 1'b1;
        end else if (state.gating[hha_pkg::SINGLE_BIT]) begin
            // Without history, fall back to the latest word
            next_state.out_word = i_tuning_word;
            next_state.out_valid = 1'b1;
        end else begin
            next_state.out_valid = 1'b0;
        end
        next_state.averaging = (next_state.phase == hha_pkg::ST_AVERAGE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= '0;
            // Configuration registers take their reset values
            state.period <= hha_pkg::PERIOD_RESET;
            state.gating <= hha_pkg::GATING_RESET;
            state.holdoff <= hha_pkg::HOLDOFF_RESET;
            state.phase <= hha_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_rdata = state.rdata;
    assign o_history_valid = state.have_history;
    assign o_holdover_valid = state.out_valid;
    assign o_holdover_word = state.out_word;
    assign o_averaging = state.averaging;
endmodule : hha_ctrl
`default_nettype wire

//--- sim/hha_ctrl_chk.sv
// Purpose: Port checks for the history accumulator control.
// Assumes: Gating and hold-off writes are shadowed from the bus.
// Notes: Bound to every hha_ctrl instance.
`timescale 1ns/100ps
`default_nettype none
module hha_ctrl_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire hha_pkg::hha_bus_s i_bus,
    input wire logic [7:0] o_rdata,
    // Loop side
    input wire hha_pkg::hha_loop_s i_loop,
    input wire logic [45:0] i_tuning_word,
    // Results
    input wire logic o_history_valid,
    input wire logic o_holdover_valid,
    input wire logic [45:0] o_holdover_word,
    input wire logic o_averaging
);
    logic [7:0] gate;
    logic [7:0] hold;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            gate <= hha_pkg::GATING_RESET;
            hold <= hha_pkg::HOLDOFF_RESET;
        end else if (i_bus.wr && i_bus.addr == hha_pkg::OFS_GATING) begin
            gate <= i_bus.wdata;
        end else if (i_bus.wr && i_bus.addr == hha_pkg::OFS_HOLDOFF) begin
            hold <= i_bus.wdata;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    byte3_top_a: assert property (i_bus.rd && i_bus.addr == hha_pkg::OFS_PERIOD_BYTE3
        |=> o_rdata[7:4] == 4'h0) else $error("period top nibble not zero");
    slew_gate_a: assert property ($rose(o_averaging) && $past(hold) == 8'h00
        |-> !($past(gate[5]) && $past(i_loop.slew_active))) else $error("slew gate ignored");
    freq_gate_a: assert property ($rose(o_averaging) && $past(hold) == 8'h00
        |-> !($past(gate[4]) && !$past(i_loop.freq_lock))) else $error("frequency gate ignored");
    phase_gate_a: assert property ($rose(o_averaging) && $past(hold) == 8'h00
        |-> !($past(gate[3]) && !$past(i_loop.phase_lock))) else $error("phase gate ignored");
    history_from_avg_a: assert property ($rose(o_history_valid) |-> $past(o_averaging))
        else $error("history without averaging");
    persist_clear_a: assert property ($fell(i_loop.holdover) && !gate[0]
        |-> ##[1:3] !o_history_valid) else $error("history kept on reacquire");
    single_word_a: assert property (o_holdover_valid && !o_history_valid
        && !$past(o_history_valid) && !$past(o_history_valid, 2)
        |-> $past(gate[1]) && (o_holdover_word == $past(i_tuning_word)
        || o_holdover_word == $past(i_tuning_word, 2))) else $error("single sample wrong");
endmodule : hha_ctrl_chk
bind hha_ctrl hha_ctrl_chk hha_ctrl_chk_i (.i_clock(i_clock), .i_rst(i_rst), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_loop(i_loop), .i_tuning_word(i_tuning_word),
    .o_history_valid(o_history_valid), .o_holdover_valid(o_holdover_valid),
    .o_holdover_word(o_holdover_word), .o_averaging(o_averaging));
`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the history accumulator control.
// Assumes: Millisecond tick is 10000 cycles.
// Notes: Read results are queued and compared by a monitor.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    hha_pkg::hha_bus_s bus = '0;
    hha_pkg::hha_loop_s loop = 4'b1001;
    logic [45:0] tw = '0;
    logic [7:0] rdata;
    logic hv, ov, avg, pend = 1'b0;
    logic [45:0] hw;
    logic [7:0] expq[$];
    logic [15:0] ofs[7] = '{16'h140a, 16'h140b, 16'h140c, 16'h140d, 16'h140e, 16'h1410, 16'h1411};
    logic [7:0] rv[7] = '{8'h0a, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00, 8'h00};
    logic [7:0] d;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 5087;
    always #50 clock = ~clock;
    hha_ctrl hha_ctrl_i (.i_clock(clock), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
        .i_loop(loop), .i_tuning_word(tw), .o_history_valid(hv), .o_holdover_valid(ov),
        .o_holdover_word(hw), .o_averaging(avg));
    task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        expq.push_back(e);
        @(posedge clock);
        bus.rd <= 1'b0;
    endtask : rd
    task automatic lp(input logic [3:0] v, input int n);
        @(posedge clock);
        loop <= v;
        repeat (n) @(posedge clock);
    endtask : lp
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (pend) begin
            chk("read data", expq.pop_front(), rdata);
        end
        pend <= bus.rd;
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        summarize();
    end
    initial begin
        tw = {14'($random(seed)), 32'($random(seed))};
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rv[i]);
        for (int i = 0; i < 3; i++) begin
            d = 8'($random(seed)) | 8'h01;
            wr(ofs[i], d);
            rd(ofs[i], d);
        end
        wr(ofs[3], 8'hff);
        rd(ofs[3], 8'h0f);
        wr(ofs[4], 8'hff);
        rd(ofs[4], 8'h3f);
        wr(ofs[6], 8'ha5);
        rd(ofs[6], 8'h00);
        wr(ofs[0], 8'h01);
        for (int i = 1; i < 4; i++) wr(ofs[i], 8'h00);
        $display("register test done");
        for (int g = 0; g < 3; g++) begin
            wr(ofs[4], 8'h38);
            lp({3'b011 ^ (3'b100 >> g), 1'b0}, 4);
            rd(16'h1412, 8'h01);
            lp(4'b0110, 4);
            rd(16'h1412, 8'h03);
            lp(4'b0111, 2);
        end
        wr(ofs[4], 8'h00);
        lp(4'b1000, 4);
        rd(16'h1412, 8'h03);
        lp(4'b1001, 2);
        $display("gating test done");
        wr(ofs[4], 8'h38);
        wr(ofs[5], 8'h01);
        lp(4'b0110, 9000);
        rd(16'h1412, 8'h02);
        repeat (1200) @(posedge clock);
        rd(16'h1412, 8'h03);
        $display("hold-off test done");
        repeat (10200) @(posedge clock);
        chk("averaging", 1, avg);
        chk("history valid", 1, hv);
        chk("holdover word", tw, hw);
        lp(4'b0111, 4);
        chk("holdover valid", 1, ov);
        lp(4'b0110, 4);
        chk("history cleared", 0, hv);
        $display("average test done");
        lp(4'b0111, 2);
        wr(ofs[5], 8'h00);
        wr(ofs[0], 8'h04);
        wr(ofs[4], 8'h3c);
        lp(4'b0110, 10300);
        chk("quick history", 1, hv);
        chk("quick word", tw, hw);
        lp(4'b0111, 2);
        wr(ofs[4], 8'h3a);
        tw <= {14'($random(seed)), 32'($random(seed))};
        lp(4'b0110, 4);
        chk("history cleared", 0, hv);
        chk("single valid", 1, ov);
        chk("single word", tw, hw);
        $display("quick and single test done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
